/* rtl/acsc_top.sv */
// Converter sequence controller: AHB-Lite register slave, sampling timer,
// slot sequencing and interrupt source prioritisation.
// Assumes the converter core presents CORE_RESULT by the last conversion tick
// and that HREADY is wired back from HREADYOUT.
module acsc_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SAMPLE_HOLD_INPUT,
  input wire logic [11:0] CORE_RESULT,
  output logic SAMPLE_WINDOW,
  output logic CONVERSION_CLOCK_EN,
  output logic [3:0] INPUT_CHANNEL_SELECT,
  output logic [2:0] REFERENCE_SELECT,
  output logic REF_GEN_POWER,
  output logic BUSY,
  output logic IRQ
);
  // Conversion clock enable.
  logic [acsc_pkg::DIV_W-1:0] div_r;
  logic conv_tick_r;
  wire div_wrap = (div_r == acsc_pkg::DIV_W'(acsc_pkg::CONV_DIV - 1));
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      div_r <= '0;
      conv_tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_wrap ? '0 : div_r + acsc_pkg::DIV_W'(1);
      conv_tick_r <= div_wrap;
    end
  end

  // Trigger synchroniser; only the second stage is read by logic.
  logic shi_s1_r, shi_s2_r, trig_prev_r;
  logic sc_r;
  wire trig_level = shi_s2_r | sc_r;
  wire trig_rise = trig_level & ~trig_prev_r;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      shi_s1_r <= 1'b0;
      shi_s2_r <= 1'b0;
      trig_prev_r <= 1'b0;
    end
    else
    begin
      shi_s1_r <= SAMPLE_HOLD_INPUT;
      shi_s2_r <= shi_s1_r;
      trig_prev_r <= trig_level;
    end
  end

  // Bus slave: writes complete with no wait, reads take one wait state so
  // that HRDATA can come from a flip-flop.
  logic rd_pend_r, wr_pend_r, hready_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  wire addr_take = HSEL & HTRANS[1] & HREADY;
  wire hit_ctrl = (addr_r == acsc_pkg::OFF_CTRL);
  wire hit_flags = (addr_r == acsc_pkg::OFF_FLAGS);
  wire hit_irqen = (addr_r == acsc_pkg::OFF_IRQEN);
  wire hit_vec = (addr_r == acsc_pkg::OFF_VECTOR);
  wire hit_entry = (addr_r[7:6] == acsc_pkg::OFF_ENTRY_SEG) && (addr_r[1:0] == 2'h0);
  wire hit_result = (addr_r[7:6] == acsc_pkg::OFF_RESULT_SEG) && (addr_r[1:0] == 2'h0);
  wire [3:0] slot_idx = addr_r[5:2];
  wire wr_ctrl = wr_pend_r & hit_ctrl;

  // Control and configuration state.
  logic en_r, msc_r, shp_r, gie_r, armed_r;
  logic [3:0] sht_lo_r, sht_hi_r, start_r;
  logic [1:0] mode_r;
  logic [7:0] entry_r [acsc_pkg::SLOTS];
  logic [acsc_pkg::RES_W-1:0] result_r [acsc_pkg::SLOTS];
  logic [15:0] flags_r, unread_r;
  logic [17:0] ien_r;
  logic ov_r, tov_r;
  wire en_rise = wr_ctrl & HWDATA[acsc_pkg::CTRL_EN_BIT] & ~en_r;

  // Sequencer state.
  acsc_pkg::acsc_state_t state_r, state_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic [6:0] samp_cnt_r;
  logic [3:0] conv_cnt_r;
  logic msc_lock_r;

  wire [7:0] cur_entry = entry_r[ptr_r];
  wire cur_eos = cur_entry[acsc_pkg::ENT_EOS_BIT];
  wire pass_end = ~mode_r[0] | cur_eos; // [RQ11]
  // A sequence pass with no end marker keeps going even with enable cleared.
  wire go_on = (mode_r[0] & ~cur_eos) | (mode_r[1] & en_r & pass_end); // [RQ18] [RQ14] [RQ15]
  wire start_ok = en_r & trig_rise & (armed_r | sc_r); // [RQ24] [RQ13]
  wire conv_done = (state_r == acsc_pkg::ST_CONV) & conv_tick_r
                   & (conv_cnt_r == 4'(acsc_pkg::CONV_CYCLES - 1)); // [RQ23]
  wire samp_end = shp_r ? (conv_tick_r & (samp_cnt_r == 7'h01)) : ~trig_level; // [RQ1]
  wire [3:0] sht_sel = ptr_nxt[3] ? sht_hi_r : sht_lo_r; // [RQ4]
  wire [6:0] samp_len = 7'(acsc_pkg::SHT_UNIT) * ({3'h0, sht_sel} + 7'h01); // [RQ3]
  wire start_sample = (state_nxt == acsc_pkg::ST_SAMPLE) && (state_r != acsc_pkg::ST_SAMPLE);
  wire start_conv = (state_nxt == acsc_pkg::ST_CONV) && (state_r != acsc_pkg::ST_CONV);
  wire run_stop = conv_done & ~go_on;
  wire busy_now = (state_r == acsc_pkg::ST_SAMPLE) || (state_r == acsc_pkg::ST_CONV);

  always_comb
  begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    case (state_r)
      acsc_pkg::ST_IDLE:
      begin
        // Idle keeps the start entry on the core-facing outputs.
        ptr_nxt = start_r; // [RQ8]
        if (start_ok)
          state_nxt = acsc_pkg::ST_SAMPLE;
      end
      acsc_pkg::ST_WAIT:
      begin
        if (~en_r & ~mode_r[0])
          state_nxt = acsc_pkg::ST_IDLE;
        else if (trig_rise)
          state_nxt = acsc_pkg::ST_SAMPLE;
      end
      acsc_pkg::ST_SAMPLE:
      begin
        if (samp_end)
          state_nxt = acsc_pkg::ST_CONV; // [RQ23]
      end
      acsc_pkg::ST_CONV:
      begin
        if (conv_done)
        begin
          // The 4-bit increment wraps 15 to 0 on its own.
          ptr_nxt = pass_end ? start_r : ptr_r + 4'h1; // [RQ9] [RQ7]
          if (~go_on)
            state_nxt = acsc_pkg::ST_IDLE;
          else if (msc_lock_r)
            state_nxt = acsc_pkg::ST_SAMPLE; // [RQ16]
          else
            state_nxt = acsc_pkg::ST_WAIT;
        end
      end
      default: state_nxt = acsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_r <= acsc_pkg::ST_IDLE;
      ptr_r <= 4'h0;
      samp_cnt_r <= 7'h00;
      conv_cnt_r <= 4'h0;
      msc_lock_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      if (start_sample)
        samp_cnt_r <= samp_len; // [RQ2]
      else if ((state_r == acsc_pkg::ST_SAMPLE) && conv_tick_r)
        samp_cnt_r <= samp_cnt_r - 7'h01;
      if (start_conv)
        conv_cnt_r <= 4'h0;
      else if ((state_r == acsc_pkg::ST_CONV) && conv_tick_r)
        conv_cnt_r <= conv_cnt_r + 4'h1;
      if (run_stop)
        msc_lock_r <= 1'b0;
      else if ((state_r == acsc_pkg::ST_IDLE) && start_ok)
        msc_lock_r <= msc_r & (mode_r != 2'h0) & shp_r; // [RQ16] [RQ17]
    end
  end

  // Result slots, flags, unread markers and overrun conditions.
  wire res_we = conv_done;
  wire [15:0] set_mask = res_we ? (16'h0001 << ptr_r) : 16'h0000; // [RQ10]
  wire [15:0] rd_clr_mask = (rd_pend_r & hit_result) ? (16'h0001 << slot_idx) : 16'h0000;
  wire ov_set = res_we & unread_r[ptr_r]; // [RQ21]
  wire tov_set = trig_rise & busy_now & ~msc_lock_r; // [RQ22] [RQ17]
  wire [17:0] pend = {tov_r, ov_r, flags_r} & ien_r;
  wire vec_access = (rd_pend_r | wr_pend_r) & hit_vec;
  wire ov_clr = vec_access & pend[acsc_pkg::SRC_OV_BIT]; // [RQ26]
  wire tov_clr = vec_access & ~pend[acsc_pkg::SRC_OV_BIT] & pend[acsc_pkg::SRC_TOV_BIT]; // [RQ26]
  wire [15:0] flags_nxt = ((wr_pend_r & hit_flags) ? HWDATA[15:0] : (flags_r & ~rd_clr_mask))
                          | set_mask; // [RQ25]

  function automatic logic [5:0] vec_of(input logic [17:0] p);
    logic [5:0] v;
    v = acsc_pkg::VEC_NONE;
    for (int i = 15; i >= 0; i--)
      if (p[i])
        v = acsc_pkg::VEC_FLAG_BASE + 6'(2 * i);
    if (p[acsc_pkg::SRC_TOV_BIT])
      v = acsc_pkg::VEC_TOV;
    if (p[acsc_pkg::SRC_OV_BIT])
      v = acsc_pkg::VEC_OV;
    return v;
  endfunction

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      flags_r <= 16'h0000;
      unread_r <= 16'h0000;
      ov_r <= 1'b0;
      tov_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      unread_r <= (unread_r & ~rd_clr_mask) | set_mask; // [RQ27]
      ov_r <= (ov_r & ~ov_clr) | ov_set;
      tov_r <= (tov_r & ~tov_clr) | tov_set;
    end
  end

  // Result storage has no reset, like the slot contents it models.
  always_ff @(posedge SYS_CLK)
  begin
    if (res_we)
      result_r[ptr_r] <= CORE_RESULT; // [RQ5] [RQ14]
  end

  // Configuration registers; timing and slot setup are locked while enabled.
  genvar g;
  generate
    for (g = 0; g < acsc_pkg::SLOTS; g++)
    begin : g_entry
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
          entry_r[g] <= 8'h00;
        else if (wr_pend_r & hit_entry & (slot_idx == 4'(g)) & ~en_r)
          entry_r[g] <= HWDATA[7:0]; // [RQ6] [RQ24]
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      en_r <= 1'b0;
      sc_r <= 1'b0;
      msc_r <= 1'b0;
      shp_r <= 1'b0;
      sht_lo_r <= 4'h0;
      sht_hi_r <= 4'h0;
      mode_r <= 2'h0;
      start_r <= 4'h0;
      gie_r <= 1'b0;
      ien_r <= 18'h00000;
      armed_r <= 1'b0;
    end
    else
    begin
      if (start_sample)
        sc_r <= 1'b0;
      if (run_stop)
        armed_r <= 1'b0; // [RQ12] [RQ13]
      if (en_rise)
        armed_r <= 1'b1;
      if (wr_ctrl)
      begin
        en_r <= HWDATA[acsc_pkg::CTRL_EN_BIT];
        sc_r <= HWDATA[acsc_pkg::CTRL_SC_BIT];
        mode_r <= HWDATA[acsc_pkg::CTRL_MODE_LSB +: 2];
        gie_r <= HWDATA[acsc_pkg::CTRL_GIE_BIT];
        if (~en_r)
        begin
          msc_r <= HWDATA[acsc_pkg::CTRL_MSC_BIT]; // [RQ24]
          shp_r <= HWDATA[acsc_pkg::CTRL_SHP_BIT];
          sht_lo_r <= HWDATA[acsc_pkg::CTRL_SHT_LO_LSB +: 4];
          sht_hi_r <= HWDATA[acsc_pkg::CTRL_SHT_HI_LSB +: 4];
          start_r <= HWDATA[acsc_pkg::CTRL_START_LSB +: 4];
        end
      end
      if (wr_pend_r & hit_irqen)
        ien_r <= HWDATA[17:0];
    end
  end

  wire [31:0] ctrl_rd = {10'h000, busy_now, gie_r, start_r, 2'h0, mode_r, sht_hi_r,
                         sht_lo_r, shp_r, msc_r, sc_r, en_r};
  wire [31:0] rdata = hit_ctrl ? ctrl_rd :
                      hit_flags ? {14'h0000, tov_r, ov_r, flags_r} :
                      hit_irqen ? {14'h0000, ien_r} :
                      hit_vec ? {26'h0000000, vec_of(pend)} :
                      hit_entry ? {24'h000000, entry_r[slot_idx]} :
                      hit_result ? {20'h00000, result_r[slot_idx]} : 32'h00000000;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hready_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end
    else
    begin
      rd_pend_r <= addr_take & ~HWRITE;
      wr_pend_r <= addr_take & HWRITE;
      if (addr_take)
        addr_r <= HADDR[7:0];
      hready_r <= ~(addr_take & ~HWRITE);
      if (rd_pend_r)
        hrdata_r <= rdata;
    end
  end

  // Core-facing and interrupt outputs, all registered.
  logic samp_win_r, busy_r, ref_pwr_r, irq_r;
  logic [3:0] chan_r;
  logic [2:0] ref_r;
  wire [7:0] nxt_entry = entry_r[ptr_nxt];
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      samp_win_r <= 1'b0;
      busy_r <= 1'b0;
      chan_r <= 4'h0;
      ref_r <= 3'h0;
      ref_pwr_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      samp_win_r <= (state_nxt == acsc_pkg::ST_SAMPLE);
      busy_r <= (state_nxt != acsc_pkg::ST_IDLE);
      chan_r <= nxt_entry[acsc_pkg::ENT_CH_LSB +: 4];
      ref_r <= nxt_entry[acsc_pkg::ENT_REF_LSB +: 3];
      ref_pwr_r <= (nxt_entry[acsc_pkg::ENT_CH_LSB +: 4] == acsc_pkg::TEMP_CHANNEL); // [RQ19]
      irq_r <= gie_r & (|pend); // [RQ20]
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hready_r;
  assign HRESP = 1'b0;
  assign SAMPLE_WINDOW = samp_win_r;
  assign CONVERSION_CLOCK_EN = conv_tick_r;
  assign INPUT_CHANNEL_SELECT = chan_r;
  assign REFERENCE_SELECT = ref_r;
  assign REF_GEN_POWER = ref_pwr_r;
  assign BUSY = busy_r;
  assign IRQ = irq_r;

  // Checks, with helper counters that only the checks read.
  logic [6:0] h_samp_ticks, h_samp_exp;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST | start_sample)
      h_samp_ticks <= 7'h00;
    else if ((state_r == acsc_pkg::ST_SAMPLE) && conv_tick_r)
      h_samp_ticks <= h_samp_ticks + 7'h01;
    if (RST)
      h_samp_exp <= 7'h00;
    else if (start_sample)
      h_samp_exp <= samp_len;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_win_fall;
    $fell(samp_win_r);
  endsequence
  sequence s_conv_run;
    (state_r == acsc_pkg::ST_CONV) [*4];
  endsequence

  a_conv_start: assert property (s_win_fall |-> s_conv_run) // [RQ23]
    else $error("conversion did not follow sample window fall");
  a_conv_span: assert property (s_win_fall |-> ##[48:51] conv_done) // [RQ23]
    else $error("conversion length wrong");
  a_sample_length: assert property ((s_win_fall and shp_r) |-> h_samp_ticks == h_samp_exp) // [RQ2]
    else $error("sample window length differs from programmed");
  a_flag_on_write: assert property (res_we |=> flags_r[$past(ptr_r)] && unread_r[$past(ptr_r)]) // [RQ10]
    else $error("result flag not set on write");
  a_overrun_set: assert property (res_we && unread_r[ptr_r] |=> ov_r) // [RQ21]
    else $error("overrun missed");
  a_time_overrun: assert property (trig_rise && busy_now && !msc_lock_r |=> tov_r) // [RQ22]
    else $error("conversion time overrun missed");
  a_ptr_wrap: assert property (res_we && mode_r[0] && ptr_r == 4'hF && !cur_eos |=> ptr_r == 4'h0) // [RQ7]
    else $error("pointer did not wrap");
  a_idle_disabled: assert property (state_r == acsc_pkg::ST_IDLE && !en_r |=> !samp_win_r) // [RQ24]
    else $error("sampling started while disabled");
  a_irq_gate: assert property (irq_r |-> $past(gie_r) && $past(|pend)) // [RQ20]
    else $error("interrupt without enables");
  a_temp_ref: assert property (chan_r == acsc_pkg::TEMP_CHANNEL |-> ref_pwr_r) // [RQ19]
    else $error("reference not powered for temperature channel");
  a_once_stops: assert property (res_we && mode_r == 2'h1 && cur_eos |=> state_r == acsc_pkg::ST_IDLE) // [RQ13]
    else $error("sequence-once did not stop");
endmodule

/* common/acsc_pkg.sv */
// Constants, register map and types of the converter sequence controller.
// Assumes one 50 MHz system clock; the conversion clock is an enable pulse from a divider.
// Operation
// RQ1: Pulse-sample select set: a trigger starts the sampling timer.
// RQ2: Sample window stays high for the programmed interval after the trigger is synchronised.
// RQ3: Sample-time fields count in units of four conversion-clock cycles.
// RQ4: Entries 0 to 7 use the low bank, entries 8 to 15 the high bank.
// RQ5: Sixteen result slots, each with its own control entry.
// RQ6: Entry holds reference select, input channel and end-of-sequence bit.
// RQ7: Sequence pointer wraps from slot 15 to slot 0 without end-of-sequence.
// RQ8: Start slot picks the first entry, or the only one in single modes.
// RQ9: Hidden pointer advances after each conversion until an end-of-sequence entry.
// RQ10: Writing a result sets that slot's result flag.
// RQ11: Mode 00 single, 01 sequence, 10 repeat single, 11 repeat sequence.
// RQ12: Software convert retriggers single mode; other triggers need an enable toggle.
// RQ13: Sequence-once stops after end-of-sequence; pin triggers need an enable toggle.
// RQ14: Repeat single converts continuously into the same slot.
// RQ15: Repeat sequence ends each pass at end-of-sequence, restarts on next trigger.
// RQ16: Multi-sample-convert: first edge starts, later conversions follow back to back.
// RQ17: Multi-sample-convert ignores edges until sequence ends or enable toggles.
// RQ18: Without end-of-sequence, clearing enable does not stop a sequence mode.
// RQ19: Channel 1010 selects temperature sensor and powers the reference generator.
// RQ20: Eighteen sources; each needs its own enable and the global enable.
// RQ21: Result overrun when a slot is rewritten before being read.
// RQ22: Conversion-time overrun when a request arrives during a conversion.
// RQ23: Conversion starts on sample window fall and takes thirteen cycles.
// RQ24: No conversion without enable; most control bits locked while enabled.
// RQ25: Reading a result slot clears its flag; software may clear flags.
// RQ26: Vector access clears overrun or time overrun when it is highest pending.
// RQ27: Per-slot unread marker set on write, cleared on read.
package acsc_pkg;
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int CONV_CLK_HZ = 12_500_000;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int DIV_W = 2;
  localparam int CONV_CYCLES = 13;
  localparam int SHT_UNIT = 4;
  localparam int SLOTS = 16;
  localparam int RES_W = 12;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_IRQEN = 8'h08;
  localparam logic [7:0] OFF_VECTOR = 8'h0C;
  localparam logic [1:0] OFF_ENTRY_SEG = 2'h1;
  localparam logic [1:0] OFF_RESULT_SEG = 2'h2;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SC_BIT = 1;
  localparam int CTRL_MSC_BIT = 2;
  localparam int CTRL_SHP_BIT = 3;
  localparam int CTRL_SHT_LO_LSB = 4;
  localparam int CTRL_SHT_HI_LSB = 8;
  localparam int CTRL_MODE_LSB = 12;
  localparam int CTRL_START_LSB = 16;
  localparam int CTRL_GIE_BIT = 20;
  localparam int ENT_CH_LSB = 0;
  localparam int ENT_REF_LSB = 4;
  localparam int ENT_EOS_BIT = 7;
  localparam int SRC_OV_BIT = 16;
  localparam int SRC_TOV_BIT = 17;

  localparam logic [3:0] TEMP_CHANNEL = 4'hA;
  localparam logic [5:0] VEC_NONE = 6'h00;
  localparam logic [5:0] VEC_OV = 6'h02;
  localparam logic [5:0] VEC_TOV = 6'h04;
  localparam logic [5:0] VEC_FLAG_BASE = 6'h06;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_CONV} acsc_state_t;
endpackage

/* dv/acsc_core_model.sv */
// Stand-in for the converter core: returns a code built from the selected channel.
// Assumes it runs on the controller's system clock and sees the controller outputs.
module acsc_core_model (
  input wire logic SYS_CLK,
  input wire logic SAMPLE_WINDOW,
  input wire logic BUSY,
  input wire logic [3:0] INPUT_CHANNEL_SELECT,
  output logic [11:0] CORE_RESULT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] code;
  assign code = {8'h3C, INPUT_CHANNEL_SELECT};
  // While BUSY is low or SAMPLE_WINDOW is high the code is inverted, so a result taken at the wrong time shows up.
  always_ff @(posedge SYS_CLK)
    CORE_RESULT <= (BUSY && !SAMPLE_WINDOW) ? code : ~code;
endmodule

/* dv/test_adc_sequence_control.sv */
// Self-checking bench for the converter sequence controller.
// Assumes one 50 MHz clock, HREADY fed back from HREADYOUT and the core model on the result.
module test_adc_sequence_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic SYS_CLK, RST, HSEL, HWRITE, SAMPLE_HOLD_INPUT, HREADYOUT, HRESP;
  logic SAMPLE_WINDOW, CONVERSION_CLOCK_EN, REF_GEN_POWER, BUSY, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, REFERENCE_SELECT;
  logic [3:0] INPUT_CHANNEL_SELECT;
  logic [11:0] CORE_RESULT;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int win_cnt = 0;
  int win_len = 0;
  int tick_gap = 0;

  acsc_top u_acsc_top (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SAMPLE_HOLD_INPUT, .CORE_RESULT,
    .SAMPLE_WINDOW, .CONVERSION_CLOCK_EN, .INPUT_CHANNEL_SELECT, .REFERENCE_SELECT,
    .REF_GEN_POWER, .BUSY, .IRQ);
  acsc_core_model u_acsc_core_model (.SYS_CLK, .SAMPLE_WINDOW, .BUSY,
    .INPUT_CHANNEL_SELECT, .CORE_RESULT);

  initial
  begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // Keeps the length of the last sample window in system cycles.
  always @(posedge SYS_CLK)
  begin
    cycles <= cycles + 1;
    if (SAMPLE_WINDOW === 1'b1)
      win_cnt <= win_cnt + 1;
    else if (win_cnt != 0)
    begin
      win_len <= win_cnt;
      win_cnt <= 0;
    end
    // The conversion tick must come every divider period once it has started.
    if (RST === 1'b1)
      tick_gap <= 0;
    else if (CONVERSION_CLOCK_EN === 1'b1)
    begin
      tick_gap <= 1;
      if (tick_gap != 0 && tick_gap != acsc_pkg::CONV_DIV)
      begin
        err_count++;
        $display("[ERR] %0t conversion tick spacing %0d", $time, tick_gap);
      end
    end
    else if (tick_gap != 0)
      tick_gap <= tick_gap + 1;
    if (cycles == 30000)
    begin
      err_count++;
      $display("[ERR] %0t run hung", $time);
      complete_run;
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
    chk({31'h0, HRESP}, 32'h0);
  endtask

  task automatic wait_idle;
    repeat (4) @(posedge SYS_CLK);
    do @(posedge SYS_CLK); while (BUSY !== 1'b0);
    repeat (4) @(posedge SYS_CLK);
  endtask

  // The window is 4*(field+1) conversion ticks; synchronisation costs a few system cycles.
  task automatic chk_win(input int f);
    int e;
    e = acsc_pkg::SHT_UNIT * (f + 1) * acsc_pkg::CONV_DIV;
    num_checks++;
    if (win_len < e - 4 || win_len > e + 4)
    begin
      err_count++;
      $display("[ERR] %0t window %0d cycles, expected %0d", $time, win_len, e);
    end
  endtask

  function automatic logic [7:0] ent(input logic [3:0] n);
    ent = {acsc_pkg::OFF_ENTRY_SEG, n, 2'h0};
  endfunction

  function automatic logic [7:0] res(input logic [3:0] n);
    res = {acsc_pkg::OFF_RESULT_SEG, n, 2'h0};
  endfunction

  function automatic logic [31:0] ctl(input logic en, sc, multi_sample_convert, input logic [3:0] lo, hi,
    input logic [1:0] md, input logic [3:0] st);
    ctl = 32'h0;
    ctl[acsc_pkg::CTRL_EN_BIT] = en;
    ctl[acsc_pkg::CTRL_SC_BIT] = sc;
    ctl[acsc_pkg::CTRL_MSC_BIT] = multi_sample_convert;
    ctl[acsc_pkg::CTRL_SHP_BIT] = 1'b1;
    ctl[acsc_pkg::CTRL_SHT_LO_LSB +: 4] = lo;
    ctl[acsc_pkg::CTRL_SHT_HI_LSB +: 4] = hi;
    ctl[acsc_pkg::CTRL_MODE_LSB +: 2] = md;
    ctl[acsc_pkg::CTRL_START_LSB +: 4] = st;
    ctl[acsc_pkg::CTRL_GIE_BIT] = 1'b1;
  endfunction

  initial
  begin
    RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    SAMPLE_HOLD_INPUT = 1'b0;
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(acsc_pkg::OFF_CTRL, ALL, 32'h0);
    rd(acsc_pkg::OFF_FLAGS, ALL, 32'h0);
    rd(acsc_pkg::OFF_IRQEN, ALL, 32'h0);
    rd(acsc_pkg::OFF_VECTOR, ALL, 32'h0);
    wr(8'h30, ALL);
    rd(8'h30, ALL, 32'h0);
    $display("reset test done");
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h0, 4'h2, 2'h0, 4'h3));
    repeat (10) @(posedge SYS_CLK);
    chk({31'h0, BUSY}, 32'h0);
    wr(ent(4'h3), 32'h25);
    wr(ent(4'h9), 32'h18);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 4'h0, 4'h2, 2'h0, 4'h3));
    chk({24'h0, REF_GEN_POWER, REFERENCE_SELECT, INPUT_CHANNEL_SELECT}, 32'h25);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h0, 4'h2, 2'h0, 4'h3));
    wait_idle;
    chk_win(0);
    rd(acsc_pkg::OFF_FLAGS, ALL, 32'h8);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 4'h0, 4'h2, 2'h0, 4'h9));
    rd(acsc_pkg::OFF_CTRL, 32'h000F0000, 32'h00030000);
    rd(res(4'h3), 32'hFFF, 32'h3C5);
    rd(acsc_pkg::OFF_FLAGS, 32'hFFFF, 32'h0);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 4'h0, 4'h2, 2'h0, 4'h9));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 4'h0, 4'h2, 2'h0, 4'h9));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h0, 4'h2, 2'h0, 4'h9));
    wait_idle;
    chk_win(2);
    rd(res(4'h9), 32'hFFF, 32'h3C8);
    $display("single conversion test done");
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 2'h1, 4'hE));
    wr(ent(4'hE), 32'h01);
    wr(ent(4'hF), 32'h02);
    wr(ent(4'h0), 32'h83);
    wr(ent(4'h1), 32'h84);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 4'h0, 4'h0, 2'h1, 4'hE));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, 4'h0, 4'h0, 2'h1, 4'hE));
    wait_idle;
    rd(acsc_pkg::OFF_FLAGS, ALL, 32'h0000C001);
    rd(res(4'hE), 32'hFFF, 32'h3C1);
    rd(res(4'hF), 32'hFFF, 32'h3C2);
    rd(res(4'h0), 32'hFFF, 32'h3C3);
    rd(acsc_pkg::OFF_FLAGS, ALL, 32'h0);
    $display("sequence once test done");
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'h1, 4'h0, 2'h2, 4'h6));
    wr(ent(4'h6), 32'h5A);
    wr(acsc_pkg::OFF_IRQEN, 32'h10000);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 4'h1, 4'h0, 2'h2, 4'h6));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, 4'h1, 4'h0, 2'h2, 4'h6));
    do @(posedge SYS_CLK); while (IRQ !== 1'b1);
    chk({28'h0, REF_GEN_POWER, REFERENCE_SELECT}, 32'hD);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'h1, 4'h0, 2'h2, 4'h6));
    wait_idle;
    rd(acsc_pkg::OFF_FLAGS, 32'h1FFFF, 32'h10040);
    rd(acsc_pkg::OFF_VECTOR, ALL, 32'h2);
    rd(acsc_pkg::OFF_VECTOR, ALL, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    rd(acsc_pkg::OFF_FLAGS, 32'h40, 32'h40);
    rd(res(4'h6), 32'hFFF, 32'h3CA);
    $display("repeat single test done");
    wr(acsc_pkg::OFF_FLAGS, 32'h0);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 2'h3, 4'h4));
    wr(ent(4'h4), 32'h06);
    wr(ent(4'h5), 32'h87);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 4'h0, 4'h0, 2'h3, 4'h4));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, 4'h0, 4'h0, 2'h3, 4'h4));
    do bus(1'b0, acsc_pkg::OFF_FLAGS, 32'h0); while (q[5:4] !== 2'h3);
    // Leave through a single-channel mode first, which ends the run after the conversion in progress.
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 4'h0, 4'h0, 2'h0, 4'h4));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 2'h0, 4'h4));
    wait_idle;
    rd(acsc_pkg::OFF_FLAGS, 32'h70, 32'h30);
    rd(res(4'h5), 32'hFFF, 32'h3C7);
    $display("repeat sequence test done");
    wr(acsc_pkg::OFF_IRQEN, 32'h20000);
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 4'hF, 4'h0, 2'h0, 4'h2));
    wr(acsc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 4'hF, 4'h0, 2'h0, 4'h2));
    SAMPLE_HOLD_INPUT <= 1'b1;
    repeat (20) @(posedge SYS_CLK);
    SAMPLE_HOLD_INPUT <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    SAMPLE_HOLD_INPUT <= 1'b1;
    wait_idle;
    chk_win(15);
    rd(acsc_pkg::OFF_FLAGS, 32'h20004, 32'h20004);
    rd(acsc_pkg::OFF_VECTOR, ALL, 32'h4);
    rd(acsc_pkg::OFF_VECTOR, ALL, 32'h0);
    SAMPLE_HOLD_INPUT <= 1'b0;
    repeat (10) @(posedge SYS_CLK);
    SAMPLE_HOLD_INPUT <= 1'b1;
    repeat (20) @(posedge SYS_CLK);
    chk({31'h0, BUSY}, 32'h0);
    $display("pin trigger test done");
    // Pulse select cleared: the synchronised pin level itself is the sample window.
    SAMPLE_HOLD_INPUT <= 1'b0;
    wr(acsc_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 2'h0, 4'h2));
    wr(acsc_pkg::OFF_CTRL,
       ctl(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 2'h0, 4'h2) & ~(32'h1 << acsc_pkg::CTRL_SHP_BIT));
    SAMPLE_HOLD_INPUT <= 1'b1;
    repeat (48) @(posedge SYS_CLK);
    SAMPLE_HOLD_INPUT <= 1'b0;
    wait_idle;
    chk_win(2);
    rd(res(4'h2), 32'hFFF, 32'h3C0);
    $display("extended sample test done");
    complete_run;
  end
endmodule
